// ---- hdl/odt_pkg.sv ----
package odt_pkg;
  localparam logic [2:0]  CMD_NOP       = 3'h0;
  localparam logic [2:0]  CMD_WR        = 3'h1;
  localparam logic [2:0]  CMD_RD        = 3'h2;
  localparam logic [2:0]  CMD_MRS       = 3'h3;
  localparam logic [1:0]  MR_SEL_0      = 2'h0;
  localparam logic [1:0]  MR_SEL_1      = 2'h1;
  localparam logic [1:0]  MR_SEL_2      = 2'h2;
  localparam logic [15:0] MR0_RESET     = 16'h0000;
  localparam logic [15:0] MR1_RESET     = 16'h0000;
  localparam logic [15:0] MR2_RESET     = 16'h0000;
  localparam int          MR0_BL_LO     = 0;
  localparam int          MR0_CL_LO     = 4;
  localparam int          MR0_DLL_PD    = 12;
  localparam int          MR1_NOM_A2    = 2;
  localparam int          MR1_AL_LO     = 3;
  localparam int          MR1_NOM_A6    = 6;
  localparam int          MR1_NOM_A9    = 9;
  localparam int          MR2_CWL_LO    = 3;
  localparam int          MR2_WR_LO     = 9;
  localparam int          MR2_WR_HI     = 10;
  localparam logic [1:0]  BL_FIXED8     = 2'h0;
  localparam logic [1:0]  BL_OTF        = 2'h1;
  localparam logic [1:0]  BL_FIXED4     = 2'h2;
  localparam logic [4:0]  CWL_BASE      = 5'h05;
  localparam logic [4:0]  CL_BASE       = 5'h04;
  localparam logic [4:0]  ODTL_OFFSET   = 5'h02;
  localparam logic [3:0]  ODTH4_CYCLES  = 4'h4;
  localparam logic [3:0]  ODTH8_CYCLES  = 4'h6;
  localparam logic [5:0]  CWN4_EXTRA    = 6'h04;
  localparam logic [5:0]  CWN8_EXTRA    = 6'h06;
  localparam logic [4:0]  RD_QUIET      = 5'h18;
  localparam int          PIPE_DEPTH    = 32;

  function automatic logic [4:0] odt_latency(input logic [15:0] mr0, input logic [15:0] mr1,
                                             input logic [15:0] mr2);
    logic [4:0] cwl;
    logic [4:0] cl;
    logic [4:0] al;
    cwl = CWL_BASE + {2'h0, mr2[MR2_CWL_LO +: 3]};
    cl  = CL_BASE + {2'h0, mr0[MR0_CL_LO +: 3]};
    unique case (mr1[MR1_AL_LO +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    return cwl + al - ODTL_OFFSET;
  endfunction
endpackage

// ---- hdl/odt_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface odt_if;
  logic        odt;
  logic        cmd_valid;
  logic [2:0]  cmd;
  logic        bc4;
  logic [1:0]  mr_sel;
  logic [15:0] mr_data;
  modport dev (input odt, input cmd_valid, input cmd, input bc4, input mr_sel, input mr_data);
  modport ctl (output odt, output cmd_valid, output cmd, output bc4, output mr_sel, output mr_data);
endinterface
`default_nettype wire

// ---- hdl/odt_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Synchronous timing while DLL is locked.
// - Controller keeps termination off in DLL-off.
// - Termination follows ODT after ODTLon/ODTLoff.
// - Both latencies equal write latency minus two.
// - Internal ODT delayed by additive latency.
// - Controller holds ODT high four cycles minimum unless DLL-off entry cuts it.
// - Write with ODT high extends hold 4/6.
// - Controller drops ODT around reads.
// - Termination returns when device stops driving.
// - Dynamic ODT enabled by MR2 A9/A10.
// - Nominal from MR1, write value from MR2.
// - Nominal strength outside writes, pin timing.
// - Write strength WL-2 after write command.
// - Nominal again ODTLoff plus 4 or 6.
// - Controller clears MR2 write termination for DLL-off.
// - ODT low means off; no command decode.
// - ODT ignored when all termination bits zero.
// - Termination off during self-refresh.
module odt_dev (
  input  wire logic clk,
  input  wire logic reset_n,
  odt_if.dev        pins,
  input  wire logic dll_locked,
  input  wire logic self_refresh,
  input  wire logic dq_driving,
  output logic      sync_mode,
  output logic      rtt_on,
  output logic      rtt_write_sel,
  output logic [2:0] rtt_code,
  output logic [4:0] odt_lat
);
  import odt_pkg::*;

  logic [15:0]           mr0_reg;
  logic [15:0]           mr0_next;
  logic [15:0]           mr1_reg;
  logic [15:0]           mr1_next;
  logic [15:0]           mr2_reg;
  logic [15:0]           mr2_next;
  logic [4:0]            lat_reg;
  logic [4:0]            lat_next;
  logic [PIPE_DEPTH-1:0] pipe_reg;
  logic [PIPE_DEPTH-1:0] pipe_next;
  logic                  wr_act_reg;
  logic                  wr_act_next;
  logic [5:0]            wr_cnt_reg;
  logic [5:0]            wr_cnt_next;
  logic [5:0]            wr_len_reg;
  logic [5:0]            wr_len_next;
  logic                  on_reg;
  logic                  on_next;
  logic                  wsel_reg;
  logic                  wsel_next;
  logic [2:0]            code_reg;
  logic [2:0]            code_next;
  logic                  odt_enabled;
  logic                  dyn_enabled;
  logic                  odt_seen;
  logic                  is_write;
  logic                  is_mrs;
  logic [5:0]            lat6;

  always_comb begin
    is_write    = pins.cmd_valid && (pins.cmd == CMD_WR);
    is_mrs      = pins.cmd_valid && (pins.cmd == CMD_MRS);
    dyn_enabled = mr2_reg[MR2_WR_HI] | mr2_reg[MR2_WR_LO];
    odt_enabled = mr1_reg[MR1_NOM_A2] | mr1_reg[MR1_NOM_A6] | mr1_reg[MR1_NOM_A9] | dyn_enabled;
    // The pin, gated only by the enable bits and self-refresh, decides on/off; read and write decode never gate the sample.
    odt_seen    = pins.odt && odt_enabled && !self_refresh;
    lat6        = {1'b0, lat_reg};
  end

  always_comb begin
    mr0_next = mr0_reg;
    mr1_next = mr1_reg;
    mr2_next = mr2_reg;
    if (is_mrs) begin
      unique case (pins.mr_sel)
        MR_SEL_0: mr0_next = pins.mr_data;
        MR_SEL_1: mr1_next = pins.mr_data;
        MR_SEL_2: mr2_next = pins.mr_data;
        default:  mr0_next = mr0_reg;
      endcase
    end
    // Latency is a flop so the long adder chain stays off the pipeline tap path.
    lat_next = odt_latency(mr0_reg, mr1_reg, mr2_reg);
  end

  always_comb begin
    pipe_next = {pipe_reg[PIPE_DEPTH-2:0], odt_seen};
    sync_mode = dll_locked;
    if (sync_mode) begin
      on_next = pipe_reg[lat_reg - 5'h01];
    end else begin
      on_next = odt_seen;
    end
    // The device cannot terminate and drive at once; termination comes back as driving ends.
    if (dq_driving || self_refresh) begin
      on_next = 1'b0;
    end
  end

  always_comb begin
    wr_act_next = wr_act_reg;
    wr_len_next = wr_len_reg;
    wr_cnt_next = (wr_cnt_reg == 6'h3F) ? wr_cnt_reg : wr_cnt_reg + 6'h01;
    wsel_next   = wsel_reg;
    if (is_write && dyn_enabled) begin
      wr_act_next = 1'b1;
      wr_cnt_next = 6'h00;
      unique case (mr0_reg[MR0_BL_LO +: 2])
        BL_FIXED4: wr_len_next = CWN4_EXTRA;
        BL_OTF:    wr_len_next = pins.bc4 ? CWN4_EXTRA : CWN8_EXTRA;
        default:   wr_len_next = CWN8_EXTRA;
      endcase
    end
    if (!dyn_enabled) begin
      wr_act_next = 1'b0;
      wsel_next   = 1'b0;
    end else if (wr_act_reg || is_write) begin
      if (wr_cnt_next == lat6) begin
        wsel_next = 1'b1;
      end else if (wr_cnt_next == lat6 + wr_len_next) begin
        wsel_next   = 1'b0;
        wr_act_next = 1'b0;
      end
    end
    if (!on_next) begin
      code_next = 3'h0;
    end else if (wsel_next) begin
      code_next = {1'b0, mr2_reg[MR2_WR_HI], mr2_reg[MR2_WR_LO]};
    end else begin
      code_next = {mr1_reg[MR1_NOM_A9], mr1_reg[MR1_NOM_A6], mr1_reg[MR1_NOM_A2]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mr0_reg    <= MR0_RESET;
      mr1_reg    <= MR1_RESET;
      mr2_reg    <= MR2_RESET;
      lat_reg    <= 5'h03;
      pipe_reg   <= '0;
      wr_act_reg <= 1'b0;
      wr_cnt_reg <= 6'h3F;
      wr_len_reg <= 6'h06;
      on_reg     <= 1'b0;
      wsel_reg   <= 1'b0;
      code_reg   <= 3'h0;
    end else begin
      mr0_reg    <= mr0_next;
      mr1_reg    <= mr1_next;
      mr2_reg    <= mr2_next;
      lat_reg    <= lat_next;
      pipe_reg   <= pipe_next;
      wr_act_reg <= wr_act_next;
      wr_cnt_reg <= wr_cnt_next;
      wr_len_reg <= wr_len_next;
      on_reg     <= on_next;
      wsel_reg   <= wsel_next;
      code_reg   <= code_next;
    end
  end

  assign rtt_on        = on_reg;
  assign rtt_write_sel = wsel_reg;
  assign rtt_code      = code_reg;
  assign odt_lat       = lat_reg;
endmodule
`default_nettype wire

// ---- hdl/odt_ctl.sv ----
`timescale 1ns/1ns
`default_nettype none
module odt_ctl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  odt_if.ctl               pins,
  input  wire logic        odt_req,
  input  wire logic        wr_req,
  input  wire logic        wr_bc4,
  input  wire logic        rd_req,
  input  wire logic        mrs_req,
  input  wire logic [1:0]  mrs_sel,
  input  wire logic [15:0] mrs_data,
  input  wire logic        dll_off_req,
  output logic             cmd_ready,
  output logic             rd_ready,
  output logic             dll_off_done
);
  import odt_pkg::*;

  typedef enum logic [2:0] {
    CT_RUN = 3'b001,
    CT_MRS = 3'b010,
    CT_OFF = 3'b100
  } odt_ctl_state_e;

  odt_ctl_state_e st_reg;
  odt_ctl_state_e st_next;
  logic           odt_reg;
  logic           odt_next;
  logic [3:0]     hold_reg;
  logic [3:0]     hold_next;
  logic [4:0]     quiet_reg;
  logic [4:0]     quiet_next;
  logic [15:0]    mr2_shadow_reg;
  logic [15:0]    mr2_shadow_next;
  logic           cv_reg;
  logic           cv_next;
  logic [2:0]     cmd_reg;
  logic [2:0]     cmd_next;
  logic           bc4_reg;
  logic           bc4_next;
  logic [1:0]     sel_reg;
  logic [1:0]     sel_next;
  logic [15:0]    data_reg;
  logic [15:0]    data_next;
  logic [3:0]     wr_hold;

  always_comb begin
    cmd_ready    = (st_reg != CT_MRS);
    // Reads wait until the pin is low and no hold is pending, so the bus is never terminated and driven.
    rd_ready     = cmd_ready && !odt_reg && !odt_req && (hold_reg == 4'h0);
    dll_off_done = (st_reg == CT_OFF);
    wr_hold      = wr_bc4 ? ODTH4_CYCLES - 4'h1 : ODTH8_CYCLES - 4'h1;
  end

  always_comb begin
    st_next         = st_reg;
    mr2_shadow_next = mr2_shadow_reg;
    cv_next         = 1'b0;
    cmd_next        = CMD_NOP;
    bc4_next        = 1'b0;
    sel_next        = sel_reg;
    data_next       = data_reg;
    quiet_next      = (quiet_reg == 5'h00) ? 5'h00 : quiet_reg - 5'h01;
    unique case (st_reg)
      CT_RUN: begin
        if (dll_off_req) begin
          st_next = CT_MRS;
        end
      end
      CT_MRS: begin
        cv_next         = 1'b1;
        cmd_next        = CMD_MRS;
        sel_next        = MR_SEL_2;
        data_next       = mr2_shadow_reg & ~16'h0600;
        mr2_shadow_next = mr2_shadow_reg & ~16'h0600;
        st_next         = CT_OFF;
      end
      CT_OFF: begin
        if (!dll_off_req) begin
          st_next = CT_RUN;
        end
      end
      default: st_next = CT_RUN;
    endcase
    if (cmd_ready && !(st_reg == CT_RUN && dll_off_req)) begin
      if (mrs_req) begin
        cv_next   = 1'b1;
        cmd_next  = CMD_MRS;
        sel_next  = mrs_sel;
        data_next = mrs_data;
        if (mrs_sel == MR_SEL_2) begin
          // While the DLL is off the write termination bits are kept at zero.
          data_next       = (st_reg == CT_OFF) ? (mrs_data & ~16'h0600) : mrs_data;
          mr2_shadow_next = data_next;
        end
      end else if (wr_req) begin
        cv_next  = 1'b1;
        cmd_next = CMD_WR;
        bc4_next = wr_bc4;
      end else if (rd_req && rd_ready) begin
        cv_next    = 1'b1;
        cmd_next   = CMD_RD;
        quiet_next = RD_QUIET;
      end
    end
  end

  always_comb begin
    hold_next = (hold_reg == 4'h0) ? 4'h0 : hold_reg - 4'h1;
    if (st_reg != CT_RUN) begin
      odt_next  = 1'b0;
      hold_next = 4'h0;
    end else if (hold_reg != 4'h0) begin
      odt_next = 1'b1;
    end else if (quiet_next != 5'h00 || quiet_reg != 5'h00) begin
      odt_next = 1'b0;
    end else begin
      odt_next = odt_req;
    end
    if (odt_next && !odt_reg) begin
      hold_next = ODTH4_CYCLES - 4'h1;
    end
    if (cmd_next == CMD_WR && odt_next && wr_hold > hold_next) begin
      hold_next = wr_hold;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg         <= CT_RUN;
      odt_reg        <= 1'b0;
      hold_reg       <= 4'h0;
      quiet_reg      <= 5'h00;
      mr2_shadow_reg <= MR2_RESET;
      cv_reg         <= 1'b0;
      cmd_reg        <= CMD_NOP;
      bc4_reg        <= 1'b0;
      sel_reg        <= MR_SEL_0;
      data_reg       <= 16'h0000;
    end else begin
      st_reg         <= st_next;
      odt_reg        <= odt_next;
      hold_reg       <= hold_next;
      quiet_reg      <= quiet_next;
      mr2_shadow_reg <= mr2_shadow_next;
      cv_reg         <= cv_next;
      cmd_reg        <= cmd_next;
      bc4_reg        <= bc4_next;
      sel_reg        <= sel_next;
      data_reg       <= data_next;
    end
  end

  assign pins.odt       = odt_reg;
  assign pins.cmd_valid = cv_reg;
  assign pins.cmd       = cmd_reg;
  assign pins.bc4       = bc4_reg;
  assign pins.mr_sel    = sel_reg;
  assign pins.mr_data   = data_reg;
endmodule
`default_nettype wire

// ---- tb/odt_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module odt_chk
  import odt_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        odt,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd,
  input wire logic        bc4,
  input wire logic [1:0]  mr_sel,
  input wire logic [15:0] mr_data,
  input wire logic        rtt_on,
  input wire logic        rtt_write_sel,
  input wire logic [4:0]  odt_lat,
  input wire logic        sync_mode,
  input wire logic        dq_driving,
  input wire logic        self_refresh,
  input wire logic        dll_off_done
);
  import odt_pkg::*;
  // Histories let a latency taken from odt_lat be checked without variable delays.
  logic [31:0] ohist_reg;
  logic [31:0] ohist_next;
  logic [31:0] whist_reg;
  logic [31:0] whist_next;
  always_comb begin
    // Self-refresh masks the pin at the sampling edge as in the device; the device's enable-bit gating is not applied here.
    ohist_next = {ohist_reg[30:0], odt && !self_refresh};
    whist_next = {whist_reg[30:0], cmd_valid && cmd == CMD_WR};
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ohist_reg <= 32'h0;
      whist_reg <= 32'h0;
    end else begin
      ohist_reg <= ohist_next;
      whist_reg <= whist_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_odt_hold_min: assert property ($rose(odt) |-> odt[*4])
    else $error("odt released early");
  chk_write_hold_min: assert property (cmd_valid && cmd == CMD_WR && odt && !bc4 |-> odt[*6])
    else $error("odt released early after write");
  chk_dll_off_quiet: assert property (dll_off_done |-> !odt)
    else $error("odt high in dll off");
  chk_mrs_clears_dyn: assert property (dll_off_done && cmd_valid && cmd == CMD_MRS && mr_sel == MR_SEL_2
                                       |-> mr_data[10:9] == 2'h0)
    else $error("dynamic termination left set");
  chk_on_latency: assert property ($rose(rtt_on) && sync_mode |-> ohist_reg[odt_lat])
    else $error("termination on at wrong cycle");
  chk_off_latency: assert property ($fell(rtt_on) && sync_mode && !dq_driving && !self_refresh
                                    |-> !ohist_reg[odt_lat])
    else $error("termination off at wrong cycle");
  chk_write_strength: assert property ($rose(rtt_write_sel) |-> whist_reg[odt_lat])
    else $error("write strength at wrong cycle");
  chk_nominal_return: assert property ($fell(rtt_write_sel)
                                       |-> whist_reg[odt_lat + 5'h4] || whist_reg[odt_lat + 5'h6])
    else $error("nominal strength at wrong cycle");
  chk_read_drive_off: assert property (dq_driving |=> !rtt_on)
    else $error("termination on while driving");
  chk_refresh_off: assert property (self_refresh |=> !rtt_on)
    else $error("termination on in self refresh");
  cover property ($rose(rtt_on));
  cover property ($fell(rtt_write_sel));
  cover property (dll_off_done && cmd_valid);
endmodule
`default_nettype wire

// ---- tb/dram_on_die_termination_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module dram_on_die_termination_control_test;
  import odt_pkg::*;
  logic        clk, reset_n, odt_req, wr_req, wr_bc4, rd_req, mrs_req, dll_off_req;
  logic        dll_locked, self_refresh, dq_driving, sync_mode, rtt_on, rtt_write_sel;
  logic        cmd_ready, rd_ready, dll_off_done;
  logic [1:0]  mrs_sel;
  logic [15:0] mrs_data;
  logic [2:0]  rtt_code;
  logic [4:0]  odt_lat;
  int          failures, comparisons, n, m;
  odt_if bus ();
  odt_dev odt_dev_inst (.clk(clk), .reset_n(reset_n), .pins(bus), .dll_locked(dll_locked),
    .self_refresh(self_refresh), .dq_driving(dq_driving), .sync_mode(sync_mode), .rtt_on(rtt_on),
    .rtt_write_sel(rtt_write_sel), .rtt_code(rtt_code), .odt_lat(odt_lat));
  odt_ctl odt_ctl_inst (.clk(clk), .reset_n(reset_n), .pins(bus), .odt_req(odt_req), .wr_req(wr_req),
    .wr_bc4(wr_bc4), .rd_req(rd_req), .mrs_req(mrs_req), .mrs_sel(mrs_sel), .mrs_data(mrs_data),
    .dll_off_req(dll_off_req), .cmd_ready(cmd_ready), .rd_ready(rd_ready), .dll_off_done(dll_off_done));
  odt_chk odt_chk_inst (.clk(clk), .reset_n(reset_n), .odt(bus.odt), .cmd_valid(bus.cmd_valid),
    .cmd(bus.cmd), .bc4(bus.bc4), .mr_sel(bus.mr_sel), .mr_data(bus.mr_data), .rtt_on(rtt_on),
    .rtt_write_sel(rtt_write_sel), .odt_lat(odt_lat), .sync_mode(sync_mode), .dq_driving(dq_driving),
    .self_refresh(self_refresh), .dll_off_done(dll_off_done));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic hit(input int sel);
    case (sel)
      0: return bus.odt === 1'b0;
      1: return rtt_on === 1'b1;
      2: return rtt_on === 1'b0;
      3: return rtt_write_sel === 1'b1;
      4: return rtt_write_sel === 1'b0;
      default: return dll_off_done === 1'b1;
    endcase
  endfunction
  // Counts edges until the chosen condition holds, bounded so a stuck output cannot hang.
  task automatic upto(input int sel, output int k);
    k = 0;
    while (!hit(sel) && k < 60) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic mrs(input logic [1:0] s, input logic [15:0] d);
    mrs_sel = s;
    mrs_data = d;
    mrs_req = 1'b1;
    cyc(1);
    mrs_req = 1'b0;
    cyc(3);
  endtask
  task automatic write(input logic b, input int total);
    wr_bc4 = b;
    wr_req = 1'b1;
    cyc(1);
    wr_req = 1'b0;
    upto(3, n);
    chk("write_sel_on", 8'h07, n[7:0]);
    chk("write_code", 8'h01, {5'h0, rtt_code});
    upto(4, m);
    chk("write_sel_off", total[7:0], 8'(n + m));
  endtask
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    final_report;
  end
  initial begin
    {reset_n, odt_req, wr_req, wr_bc4, rd_req, mrs_req, dll_off_req} = 7'h00;
    {self_refresh, dq_driving, mrs_sel, mrs_data} = 20'h00000;
    dll_locked = 1'b1;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("odt_lat", 8'h03, {3'h0, odt_lat});
    odt_req = 1'b1;
    cyc(1);
    odt_req = 1'b0;
    cyc(12);
    chk("rtt_on_disabled", 8'h00, {7'h0, rtt_on});
    mrs(MR_SEL_1, 16'h0004);
    odt_req = 1'b1;
    cyc(1);
    odt_req = 1'b0;
    upto(1, n);
    // Counts start at the edge that launches the pin, one edge before the device samples it.
    chk("on_latency", 8'h04, n[7:0]);
    chk("nominal_code", 8'h01, {5'h0, rtt_code});
    upto(0, n);
    chk("odt_low", 8'h00, n[7:0]);
    upto(2, n);
    chk("off_latency", 8'h04, n[7:0]);
    mrs(MR_SEL_1, 16'h0048);
    chk("odt_lat_al", 8'h06, {3'h0, odt_lat});
    mrs(MR_SEL_2, 16'h0200);
    odt_req = 1'b1;
    cyc(1);
    upto(1, n);
    chk("on_latency_al", 8'h07, n[7:0]);
    chk("nominal_code", 8'h02, {5'h0, rtt_code});
    write(1'b0, 13);
    mrs(MR_SEL_0, 16'h0001);
    write(1'b1, 11);
    dq_driving = 1'b1;
    cyc(2);
    chk("rtt_on_driving", 8'h00, {7'h0, rtt_on});
    chk("rd_ready_odt", 8'h00, {7'h0, rd_ready});
    dq_driving = 1'b0;
    cyc(2);
    chk("rtt_on_released", 8'h01, {7'h0, rtt_on});
    self_refresh = 1'b1;
    cyc(2);
    chk("rtt_on_refresh", 8'h00, {7'h0, rtt_on});
    self_refresh = 1'b0;
    odt_req = 1'b0;
    cyc(20);
    rd_req = 1'b1;
    cyc(1);
    rd_req = 1'b0;
    chk("read_cmd", {5'h0, CMD_RD}, {5'h0, bus.cmd});
    odt_req = 1'b1;
    cyc(3);
    chk("odt_after_read", 8'h00, {7'h0, bus.odt});
    odt_req = 1'b0;
    dll_off_req = 1'b1;
    upto(5, n);
    chk("dll_off_done", 8'h01, {7'h0, dll_off_done});
    chk("odt_dll_off", 8'h00, {7'h0, bus.odt});
    chk("dll_off_mr2", 8'h00, {6'h0, bus.mr_data[10:9]});
    dll_locked = 1'b0;
    cyc(1);
    chk("sync_mode", 8'h00, {7'h0, sync_mode});
    final_report;
  end
endmodule
`default_nettype wire
